// *** tlvic_core_model.sv ***
// core model: instruction boundaries, exit instructions and return stack depth
`timescale 1ns/100ps
module tlvic_core_model (
	input  wire logic        clk_i,
	input  wire logic        mc_tick_i,
	input  wire logic        call_req_i,
	output logic             last_cycle_o,
	output logic             exit_instr_o
);
	int depth = 0;
	initial begin
		last_cycle_o = 1'b1;
		exit_instr_o = 1'b0;
	end
	// a call pushes the return address only
	always @(posedge clk_i) begin
		if (call_req_i)
			depth <= depth + 1;
	end
	// exit stands over one whole machine cycle, then pops
	task automatic do_exit();
		@(posedge clk_i iff mc_tick_i);
		exit_instr_o <= 1'b1;
		@(posedge clk_i iff mc_tick_i);
		exit_instr_o <= 1'b0;
		depth <= depth - 1;
	endtask
	// long instruction: no final cycle for n machine cycles
	task automatic stall(input int n);
		@(posedge clk_i iff mc_tick_i);
		last_cycle_o <= 1'b0;
		repeat (n) @(posedge clk_i iff mc_tick_i);
		last_cycle_o <= 1'b1;
	endtask
endmodule // tlvic_core_model

// *** tlvic_ctrl.sv ***
// module: two-level vectored interrupt controller with wishbone register slave
`timescale 1ns/100ps

module tlvic_ctrl #(
	parameter int unsigned MC_CYCLES = tlvic_pkg::MC_CLKS
) (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// request sources
	input  wire logic [6:0]               ext_pin_n_i,
	input  wire tlvic_pkg::tlvic_periph_t periph_set_i,
	// core side
	input  wire logic                     last_cycle_i,
	input  wire logic                     exit_instr_i,
	output logic                          mc_tick_o,
	output logic                          call_req_o,
	output logic      [15:0]              vector_o,
	output logic                          call_busy_o,
	output logic      [1:0]               in_prog_o
);
	import tlvic_pkg::*;

	localparam int CW = (MC_CYCLES > 1) ? $clog2(MC_CYCLES) : 1;
	// a one-clock machine cycle still keeps a one-bit counter

	// first set bit from index 0 upward gives the polling winner
	function automatic logic [4:0] pick_first(input logic [NSRC-1:0] v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction

	// divider and pin synchronisers
	logic [CW-1:0]     mc_cnt_reg;
	logic              tick;
	logic [6:0]        pin_s1_reg;
	logic [6:0]        pin_s2_reg;
	logic [6:0]        pin_prev_reg;
	// software visible configuration
	logic [7:0]        enable_reg_a;
	logic [7:0]        enable_reg_b;
	logic [7:0]        enable_reg_c;
	logic [7:0]        level_reg_a;
	logic [7:0]        level_reg_b;
	logic [7:0]        level_reg_c;
	logic [7:0]        trigger_type_reg;
	logic [7:0]        ctrl_reg;
	// request flags and their next values
	logic [6:0]        ext_flag_reg;
	logic [6:0]        ext_flag_next;
	tlvic_periph_t     pfl_reg;
	tlvic_periph_t     pfl_next;
	// polling and grant
	logic [6:0]        edge_mode;
	logic [NSRC-1:0]   src_vec;
	logic [NSRC-1:0]   samp_reg;
	logic [NSRC-1:0]   en_vec;
	logic [NSRC-1:0]   lvl_vec;
	logic [NSRC-1:0]   hi_req;
	logic [NSRC-1:0]   lo_req;
	logic              hi_ok;
	logic              lo_ok;
	logic              can_poll;
	logic              grant;
	logic [4:0]        win_idx;
	logic [6:0]        ext_clr;
	logic [N_PFL-1:0]  pfl_clr;
	// level tracking and call sequence
	logic              acc_seen_reg;
	logic              acc_now;
	logic              prog_hi_reg;
	logic              prog_lo_reg;
	tlvic_state_t      state_reg;
	logic [4:0]        last_idx_reg;
	// register bus datapath
	logic              wb_req;
	logic              wr_en;
	logic [7:0]        wdat;
	logic [7:0]        rdat;

	// machine cycle divider; its last clk is the sample point
	assign tick = (mc_cnt_reg == CW'(MC_CYCLES - 1));
	assign mc_tick_o = tick;

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			mc_cnt_reg <= '0;
		end else begin
			mc_cnt_reg <= mc_cnt_reg + 1'b1;
		end
	end

	// pins cross into the clock domain through two flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_reg   <= 7'h7f;
			pin_s2_reg   <= 7'h7f;
			pin_prev_reg <= 7'h7f;
		end else begin
			pin_s1_reg <= ext_pin_n_i;
			pin_s2_reg <= pin_s1_reg;
			if (tick) begin
				pin_prev_reg <= pin_s2_reg;
			end
		end
	end

	// wishbone: one wait state, ack for one clk, any address answered
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en = wb_req && wb_we_i && wb_sel_i[0];
	assign wdat = wb_dat_i[7:0];
	assign acc_now = wb_req && (wb_adr_i[7:2] <= OFS_LVL_C[7:2]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? {24'h000000, rdat} : '0;
		end
	end

	always_comb begin
		case ({wb_adr_i[7:2], 2'b00})
			OFS_ENA_A:  rdat = enable_reg_a;
			OFS_ENA_B:  rdat = enable_reg_b;
			OFS_ENA_C:  rdat = enable_reg_c;
			OFS_LVL_A:  rdat = level_reg_a;
			OFS_LVL_B:  rdat = level_reg_b;
			OFS_LVL_C:  rdat = level_reg_c;
			OFS_TRIG:   rdat = trigger_type_reg;
			OFS_EXT_LO: rdat = {4'h0, ext_flag_reg[3:0]};
			OFS_EXT_HI: rdat = {5'h00, ext_flag_reg[6:4]};
			OFS_PFL_LO: rdat = pfl_reg[7:0];
			OFS_PFL_HI: rdat = {3'h0, pfl_reg[12:8]};
			OFS_CTRL:   rdat = ctrl_reg;
			OFS_STAT:   rdat = {prog_hi_reg, prog_lo_reg, call_busy_o, last_idx_reg};
			default:    rdat = 8'h00;
		endcase
	end

	// configuration registers; reserved level bits are held at zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable_reg_a     <= REG_RST;
			enable_reg_b     <= REG_RST;
			enable_reg_c     <= REG_RST;
			level_reg_a      <= REG_RST;
			level_reg_b      <= REG_RST;
			level_reg_c      <= REG_RST;
			trigger_type_reg <= REG_RST;
			ctrl_reg         <= REG_RST;
		end else if (wr_en) begin
			case ({wb_adr_i[7:2], 2'b00})
				OFS_ENA_A: enable_reg_a     <= wdat & ENA_A_MASK;
				OFS_ENA_B: enable_reg_b     <= wdat & ENA_B_MASK;
				OFS_ENA_C: enable_reg_c     <= wdat & ENA_C_MASK;
				OFS_LVL_A: level_reg_a      <= wdat & LVL_A_MASK;
				OFS_LVL_B: level_reg_b      <= wdat & LVL_B_MASK;
				OFS_LVL_C: level_reg_c      <= wdat & LVL_C_MASK;
				OFS_TRIG:  trigger_type_reg <= wdat & TRIG_MASK;
				OFS_CTRL:  ctrl_reg         <= wdat & CTRL_MASK;
				default: begin
				end
			endcase
		end
	end

	// ext6 has no trigger bit and is always edge mode
	assign edge_mode = {1'b1, trigger_type_reg[5:0]};

	// sources laid out in polling order
	assign src_vec = {pfl_reg.tmr_overflow[4], pfl_reg.tmr_overflow[3], ext_flag_reg[6], ext_flag_reg[5],
		pfl_reg.sync_serial_b_request, pfl_reg.sync_serial_a_request, ext_flag_reg[4], ext_flag_reg[3],
		ext_flag_reg[2], pfl_reg.converter_done_request, pfl_reg.freq_counter_request,
		pfl_reg.watchdog_request, pfl_reg.tmr_overflow[2] | pfl_reg.tmr2_capture_event,
		pfl_reg.receive_done_flag | pfl_reg.transmit_done_flag, pfl_reg.tmr_overflow[1], ext_flag_reg[1],
		pfl_reg.tmr_overflow[0], ext_flag_reg[0]};

	// hardware clear on vectoring: edge pins and timer overflows only
	always_comb begin
		ext_clr = 7'h00;
		pfl_clr = '0;
		if (grant) begin
			case (win_idx)
				SRC_EXT0: ext_clr[0] = edge_mode[0];
				SRC_EXT1: ext_clr[1] = edge_mode[1];
				SRC_EXT2: ext_clr[2] = edge_mode[2];
				SRC_EXT3: ext_clr[3] = edge_mode[3];
				SRC_EXT4: ext_clr[4] = edge_mode[4];
				SRC_EXT5: ext_clr[5] = edge_mode[5];
				SRC_EXT6: ext_clr[6] = 1'b1;
				SRC_TMR0: pfl_clr[0] = 1'b1;
				SRC_TMR1: pfl_clr[1] = 1'b1;
				SRC_TMR2: pfl_clr[2] = 1'b1;
				SRC_TMR3: pfl_clr[3] = 1'b1;
				SRC_TMR4: pfl_clr[4] = 1'b1;
				default: begin
				end
			endcase
		end
	end

	// flag update: software write, then hardware clear, then sets win
	always_comb begin
		ext_flag_next = ext_flag_reg;
		pfl_next = pfl_reg;
		if (wr_en && ({wb_adr_i[7:2], 2'b00} == OFS_EXT_LO)) begin
			ext_flag_next[3:0] = wdat[3:0];
		end
		if (wr_en && ({wb_adr_i[7:2], 2'b00} == OFS_EXT_HI)) begin
			ext_flag_next[6:4] = wdat[2:0];
		end
		if (wr_en && ({wb_adr_i[7:2], 2'b00} == OFS_PFL_LO)) begin
			pfl_next[7:0] = wdat;
		end
		if (wr_en && ({wb_adr_i[7:2], 2'b00} == OFS_PFL_HI)) begin
			pfl_next[12:8] = wdat[4:0];
		end
		ext_flag_next = ext_flag_next & ~ext_clr;
		pfl_next = tlvic_periph_t'(pfl_next & ~pfl_clr);
		if (tick) begin
			for (int i = 0; i < N_EXT; i++) begin
				if (!edge_mode[i]) begin
					ext_flag_next[i] = !pin_s2_reg[i];
				end else if (pin_prev_reg[i] && !pin_s2_reg[i]) begin
					ext_flag_next[i] = 1'b1;
				end
			end
		end
		pfl_next = tlvic_periph_t'(pfl_next | periph_set_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_flag_reg <= 7'h00;
			pfl_reg      <= '0;
		end else begin
			ext_flag_reg <= ext_flag_next;
			pfl_reg      <= pfl_next;
		end
	end

	// sample point capture, polled during the next machine cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			samp_reg <= '0;
		end else if (tick) begin
			samp_reg <= src_vec;
		end
	end

	// enables and levels; watchdog in nmi mode bypasses both gates and is high
	always_comb begin
		en_vec = {enable_reg_c[6:0], enable_reg_b[4:0], enable_reg_a[5:0]};
		lvl_vec = {level_reg_c[6:0], level_reg_b[4:0], level_reg_a[5:0]};
		if (!enable_reg_a[GATE_BIT]) begin
			en_vec = '0;
		end
		if (ctrl_reg[NMI_BIT]) begin
			en_vec[SRC_WDT] = 1'b1;
			lvl_vec[SRC_WDT] = 1'b1;
		end
	end

	assign hi_req = samp_reg & en_vec & lvl_vec;
	assign lo_req = samp_reg & en_vec & ~lvl_vec;
	assign hi_ok = (|hi_req) && !prog_hi_reg;
	assign lo_ok = (|lo_req) && !prog_hi_reg && !prog_lo_reg;
	assign can_poll = tick && (state_reg == TLVIC_IDLE) && last_cycle_i;
	assign grant = can_poll && !exit_instr_i && !acc_seen_reg && !acc_now && (hi_ok || lo_ok);
	assign win_idx = hi_ok ? pick_first(hi_req) : pick_first(lo_req);

	// enable or level register access holds off the poll of this cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			acc_seen_reg <= 1'b0;
		end else if (acc_now) begin
			acc_seen_reg <= 1'b1;
		end
	end

	// in-progress levels; a plain return gives no exit and leaves them set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prog_hi_reg <= 1'b0;
			prog_lo_reg <= 1'b0;
		end else if (tick && exit_instr_i) begin
			if (prog_hi_reg) begin
				prog_hi_reg <= 1'b0;
			end else begin
				prog_lo_reg <= 1'b0;
			end
		end else if (grant) begin
			if (hi_ok) begin
				prog_hi_reg <= 1'b1;
			end else begin
				prog_lo_reg <= 1'b1;
			end
		end
	end

	// call sequence: two machine cycles after the granting poll
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= TLVIC_IDLE;
		end else if (tick) begin
			case (state_reg)
				TLVIC_IDLE:  state_reg <= grant ? TLVIC_CALL1 : TLVIC_IDLE;
				TLVIC_CALL1: state_reg <= TLVIC_CALL2;
				TLVIC_CALL2: state_reg <= TLVIC_IDLE;
				default:     state_reg <= TLVIC_IDLE;
			endcase
		end
	end

	// busy covers both machine cycles of the call
	assign call_busy_o = (state_reg != TLVIC_IDLE);
	assign in_prog_o = {prog_hi_reg, prog_lo_reg};

	// call request tells the core to push pc only and jump to vector_o
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			call_req_o   <= 1'b0;
			vector_o     <= 16'h0000;
			last_idx_reg <= 5'h00;
		end else begin
			call_req_o <= grant;
			if (grant) begin
				vector_o     <= VEC_BASE + (16'(win_idx) * VEC_STEP);
				last_idx_reg <= win_idx;
			end
		end
	end

endmodule // tlvic_ctrl

// *** tlvic_ctrl_assertions.sv ***
// port checker of the interrupt controller, bound to tlvic_ctrl
`timescale 1ns/100ps
module tlvic_assertions #(
	parameter int unsigned MC_CYCLES = 12
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        last_cycle_i,
	input wire logic        exit_instr_i,
	input wire logic        mc_tick_o,
	input wire logic        call_req_o,
	input wire logic [15:0] vector_o,
	input wire logic        call_busy_o,
	input wire logic [1:0]  in_prog_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [7:0] gap_cnt;
	logic [7:0] busy_cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i || mc_tick_o)
			gap_cnt <= 8'h00;
		else
			gap_cnt <= gap_cnt + 8'h01;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || !call_busy_o)
			busy_cnt <= 8'h00;
		else
			busy_cnt <= busy_cnt + 8'h01;
	end
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer is not a one clock pulse");
	tick_period_a: assert property (mc_tick_o |-> gap_cnt == 8'(MC_CYCLES - 1))
		else $error("sample tick off its period");
	call_cause_a: assert property (call_req_o |-> $past(mc_tick_o) && $past(last_cycle_i) && !$past(exit_instr_i))
		else $error("call without a granting poll");
	call_free_a: assert property (call_req_o |-> !$past(call_busy_o))
		else $error("call during a call sequence");
	busy_span_a: assert property ($fell(call_busy_o) |-> busy_cnt >= 8'(2 * MC_CYCLES) && busy_cnt <= 8'(3 * MC_CYCLES))
		else $error("call sequence length wrong");
	vector_form_a: assert property (call_req_o |-> vector_o[2:0] == 3'h3 && vector_o <= 16'h008b)
		else $error("vector outside the table");
	vector_hold_a: assert property (!call_req_o |-> $stable(vector_o))
		else $error("vector moved without a call");
	level_mark_a: assert property (call_req_o |-> in_prog_o != $past(in_prog_o))
		else $error("call left in-progress state alone");
	exit_clear_a: assert property (mc_tick_o && exit_instr_i && in_prog_o[1] |=> in_prog_o == {1'b0, $past(in_prog_o[0])})
		else $error("exit did not clear the high level");
	prog_hold_a: assert property (!mc_tick_o |=> $stable(in_prog_o))
		else $error("in-progress changed off a tick");
	cover property (call_req_o && in_prog_o == 2'b11);
	cover property (mc_tick_o && exit_instr_i);
	cover property (mc_tick_o && !last_cycle_i);
endmodule // tlvic_assertions

bind tlvic_ctrl tlvic_assertions #(.MC_CYCLES(MC_CYCLES)) chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .last_cycle_i(last_cycle_i),
	.exit_instr_i(exit_instr_i), .mc_tick_o(mc_tick_o), .call_req_o(call_req_o), .vector_o(vector_o),
	.call_busy_o(call_busy_o), .in_prog_o(in_prog_o));

// *** tlvic_pkg.sv ***
// package: constants, register map and types of the two-level vectored interrupt controller
package tlvic_pkg;

	// source count and split between pins and peripherals
	localparam int NSRC  = 18;
	localparam int N_EXT = 7;
	localparam int N_PFL = 13;

	// machine cycle length in clk cycles; the sample point is its last clk
	localparam int MC_CLKS = 12;

	// vector of polling index 0, and spacing between vectors
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_ENA_A  = 8'h00;
	localparam logic [7:0] OFS_ENA_B  = 8'h04;
	localparam logic [7:0] OFS_ENA_C  = 8'h08;
	localparam logic [7:0] OFS_LVL_A  = 8'h0c;
	localparam logic [7:0] OFS_LVL_B  = 8'h10;
	localparam logic [7:0] OFS_LVL_C  = 8'h14;
	localparam logic [7:0] OFS_TRIG   = 8'h18;
	localparam logic [7:0] OFS_EXT_LO = 8'h1c;
	localparam logic [7:0] OFS_EXT_HI = 8'h20;
	localparam logic [7:0] OFS_PFL_LO = 8'h24;
	localparam logic [7:0] OFS_PFL_HI = 8'h28;
	localparam logic [7:0] OFS_CTRL   = 8'h2c;
	localparam logic [7:0] OFS_STAT   = 8'h30;

	// reset value of every register
	localparam logic [7:0] REG_RST = 8'h00;

	// writable bits of each register
	localparam logic [7:0] ENA_A_MASK = 8'hbf;
	localparam logic [7:0] ENA_B_MASK = 8'h1f;
	localparam logic [7:0] ENA_C_MASK = 8'h7f;
	localparam logic [7:0] LVL_A_MASK = 8'h3f;
	localparam logic [7:0] LVL_B_MASK = 8'h1f;
	localparam logic [7:0] LVL_C_MASK = 8'h7f;
	localparam logic [7:0] TRIG_MASK  = 8'h3f;
	localparam logic [7:0] CTRL_MASK  = 8'h01;

	// field positions
	localparam int GATE_BIT = 7;
	localparam int NMI_BIT  = 0;
	localparam int STAT_HI  = 7;
	localparam int STAT_LO  = 6;
	localparam int STAT_BSY = 5;

	// polling index of each source, index 0 wins ties
	localparam logic [4:0] SRC_EXT0 = 5'h00;
	localparam logic [4:0] SRC_TMR0 = 5'h01;
	localparam logic [4:0] SRC_EXT1 = 5'h02;
	localparam logic [4:0] SRC_TMR1 = 5'h03;
	localparam logic [4:0] SRC_UART = 5'h04;
	localparam logic [4:0] SRC_TMR2 = 5'h05;
	localparam logic [4:0] SRC_WDT  = 5'h06;
	localparam logic [4:0] SRC_FREQ = 5'h07;
	localparam logic [4:0] SRC_CONV = 5'h08;
	localparam logic [4:0] SRC_EXT2 = 5'h09;
	localparam logic [4:0] SRC_EXT3 = 5'h0a;
	localparam logic [4:0] SRC_EXT4 = 5'h0b;
	localparam logic [4:0] SRC_SYNA = 5'h0c;
	localparam logic [4:0] SRC_SYNB = 5'h0d;
	localparam logic [4:0] SRC_EXT5 = 5'h0e;
	localparam logic [4:0] SRC_EXT6 = 5'h0f;
	localparam logic [4:0] SRC_TMR3 = 5'h10;
	localparam logic [4:0] SRC_TMR4 = 5'h11;

	// call sequence states, gray along idle -> first -> second
	typedef enum logic [1:0] {
		TLVIC_IDLE  = 2'b00,
		TLVIC_CALL1 = 2'b01,
		TLVIC_CALL2 = 2'b11
	} tlvic_state_t;

	// peripheral request flags; bits 7:0 and 12:8 form the two flag registers
	typedef struct packed {
		logic       watchdog_request;
		logic       converter_done_request;
		logic       freq_counter_request;
		logic       sync_serial_b_request;
		logic       sync_serial_a_request;
		logic       transmit_done_flag;
		logic       receive_done_flag;
		logic       tmr2_capture_event;
		logic [4:0] tmr_overflow;
	} tlvic_periph_t;

endpackage

// *** tlvic_tb.sv ***
// testbench of the interrupt controller
`timescale 1ns/100ps
module tb;
	import tlvic_pkg::*;
	localparam logic [7:0] ROFS [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h3c};
	localparam logic [7:0] RMSK [12] = '{ENA_A_MASK, ENA_B_MASK, ENA_C_MASK, LVL_A_MASK, LVL_B_MASK,
		LVL_C_MASK, TRIG_MASK, 8'hff, 8'h1f, CTRL_MASK, 8'h00, 8'h00};
	localparam logic [7:0] FOFS [18] = '{8'h1c, 8'h24, 8'h1c, 8'h24, 8'h24, 8'h24, 8'h28, 8'h28, 8'h28,
		8'h1c, 8'h1c, 8'h20, 8'h28, 8'h28, 8'h20, 8'h20, 8'h24, 8'h24};
	localparam int FBIT [18] = '{0, 0, 1, 1, 6, 2, 4, 2, 3, 2, 3, 0, 0, 1, 1, 2, 3, 4};
	localparam logic [17:0] HWCLR = 18'h3ce2f;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          cyc = 1'b0;
	logic          we = 1'b0;
	logic [7:0]    adr = 8'h00;
	logic [31:0]   wdat = 32'h0;
	logic [31:0]   rdat;
	logic [31:0]   dat_o;
	logic [6:0]    pin_n = 7'h7f;
	tlvic_periph_t pset = '0;
	logic          ack, tick, call, busy, last_c, exit_c;
	logic [15:0]   vec;
	logic [1:0]    prog;
	int            bad_count = 0;
	int            checks_done = 0;
	always #4 clk = ~clk;
	tlvic_ctrl #(.MC_CYCLES(4)) dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.ext_pin_n_i(pin_n), .periph_set_i(pset), .last_cycle_i(last_c), .exit_instr_i(exit_c),
		.mc_tick_o(tick), .call_req_o(call), .vector_o(vec), .call_busy_o(busy), .in_prog_o(prog));
	tlvic_core_model core (.clk_i(clk), .mc_tick_i(tick), .call_req_i(call), .last_cycle_o(last_c),
		.exit_instr_o(exit_c));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		@(posedge clk);
		for (n = 0; n < 50 && ack !== 1'b1; n++)
			@(posedge clk);
		rdat = dat_o;
		chk(ack, 1'b1);
		cyc <= 1'b0;
	endtask
	task automatic wcall(input logic [15:0] v);
		for (int n = 0; n < 60 && call !== 1'b1; n++)
			@(posedge clk);
		chk({call, busy, vec}, {1'b1, 1'b1, v});
	endtask
	task automatic quiet(input int c);
		repeat (c) @(posedge clk) chk(call, 1'b0);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 12; i++) begin
			wb(1'b0, ROFS[i], 8'h00);
			chk(rdat, {24'h0, REG_RST});
			wb(1'b1, ROFS[i], (i >= 3 && i <= 5) ? RMSK[i] : 8'hff);
			wb(1'b0, ROFS[i], 8'h00);
			chk(rdat, {24'h0, RMSK[i]});
			wb(1'b1, ROFS[i], 8'h00);
		end
	endtask
	task automatic t_vec();
		wb(1'b1, OFS_TRIG, 8'h3f);
		wb(1'b1, OFS_ENA_A, 8'hbf);
		wb(1'b1, OFS_ENA_B, 8'h1f);
		wb(1'b1, OFS_ENA_C, 8'h7f);
		for (int i = 0; i < NSRC; i++) begin
			wb(1'b1, FOFS[i], 8'h01 << FBIT[i]);
			wcall(16'(VEC_BASE + VEC_STEP * i));
			wb(1'b0, FOFS[i], 8'h00);
			chk(rdat[FBIT[i]], !HWCLR[i]);
			wb(1'b1, FOFS[i], 8'h00);
			core.do_exit();
		end
	endtask
	task automatic t_prio();
		wb(1'b1, OFS_LVL_C, 8'h40);
		wb(1'b1, OFS_PFL_LO, 8'h11);
		wcall(16'h008b);
		chk(prog, 2'b10);
		quiet(24);
		core.do_exit();
		wcall(16'h000b);
		wb(1'b1, OFS_PFL_LO, 8'h10);
		wcall(16'h008b);
		chk(prog, 2'b11);
		core.do_exit();
		wb(1'b1, OFS_PFL_LO, 8'h02);
		quiet(24);
		core.do_exit();
		wcall(16'h001b);
		core.do_exit();
		wb(1'b1, OFS_LVL_C, 8'h00);
	endtask
	task automatic t_gate();
		wb(1'b1, OFS_ENA_A, 8'h3f);
		wb(1'b1, OFS_PFL_LO, 8'h01);
		quiet(16);
		wb(1'b1, OFS_PFL_LO, 8'h00);
		wb(1'b1, OFS_ENA_A, 8'hbf);
		quiet(16);
		fork
			core.stall(4);
		join_none
		wb(1'b1, OFS_PFL_LO, 8'h01);
		quiet(12);
		wcall(16'h000b);
		core.do_exit();
	endtask
	task automatic t_pins();
		wb(1'b1, OFS_TRIG, 8'h3e);
		pin_n <= 7'h7e;
		wcall(16'h0003);
		wb(1'b0, OFS_EXT_LO, 8'h00);
		chk(rdat, 32'h1);
		pin_n <= 7'h7f;
		repeat (12) @(posedge clk);
		wb(1'b0, OFS_EXT_LO, 8'h00);
		chk(rdat, 32'h0);
		core.do_exit();
		pin_n <= 7'h3f;
		repeat (8) @(posedge clk);
		pin_n <= 7'h7f;
		wcall(16'h007b);
		wb(1'b0, OFS_EXT_HI, 8'h00);
		chk(rdat, 32'h0);
		core.do_exit();
		pset <= 13'h0088;
		@(posedge clk);
		pset <= '0;
		wcall(16'h0023);
		wb(1'b1, OFS_PFL_LO, 8'h08);
		core.do_exit();
		wcall(16'h0083);
		core.do_exit();
		@(posedge clk);
		chk(core.depth, 0);
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		test_done();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_vec();
		t_prio();
		t_gate();
		t_pins();
		test_done();
	end
endmodule // tb
